/* include/nvm_link_if.sv */
`timescale 1ns/1ns
interface nvm_link_if;
  logic reg_wr;
  logic [2:0] reg_idx;
  logic [7:0] reg_wdata;
  logic [2:0] rd_idx;
  logic [7:0] rd_data;
  logic stall;
  logic discard;
  modport core (
    output reg_wr,
    output reg_idx,
    output reg_wdata,
    output rd_idx,
    input rd_data,
    input stall,
    input discard
  );
  modport nvm (
    input reg_wr,
    input reg_idx,
    input reg_wdata,
    input rd_idx,
    output rd_data,
    output stall,
    output discard
  );
endinterface

/* include/nvm_pkg.sv */
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
package nvm_pkg;
  // Register indices on the link
  localparam logic [2:0] RA_ADDR_LO = 3'h0;
  localparam logic [2:0] RA_ADDR_HI = 3'h1;
  localparam logic [2:0] RA_DATA_LO = 3'h2;
  localparam logic [2:0] RA_DATA_HI = 3'h3;
  localparam logic [2:0] RA_CTRL = 3'h4;
  localparam logic [2:0] RA_UNLOCK = 3'h5;
  localparam int IDX_W = 3;
  // Control register bit positions
  localparam int B_RD = 0;
  localparam int B_WR = 1;
  localparam int B_WEN = 2;
  localparam int B_WRERR = 3;
  localparam int B_FREE = 4;
  localparam int B_LOAD_ONLY = 5;
  localparam int B_CFG_SEL = 6;
  localparam int B_PGD = 7;
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam int WORD_W = 14;
  localparam logic [13:0] ERASED_WORD = 14'h3fff;
  // Array geometry
  localparam int LATCHES = 32;
  localparam int ROW_WORDS = 32;
  localparam int FLASH_WORDS = 256;
  // Timing
  localparam int SETUP_CYCLES = 2;
  localparam int CLK_KHZ = 20000;
  localparam int ERASE_TIME_US = 2000;
  localparam int WRITE_TIME_US = 2000;
  localparam int ERASE_CYCLES = ERASE_TIME_US * CLK_KHZ / 1000;
  localparam int WRITE_CYCLES = WRITE_TIME_US * CLK_KHZ / 1000;
  localparam int CNT_W = 16;
  // Bridge register map and fields
  localparam logic [11:0] OFS_XFER = 12'h000;
  localparam logic [11:0] OFS_RDSEL = 12'h004;
  localparam logic [11:0] OFS_STATUS = 12'h008;
  localparam int XFER_IDX_LSB = 8;
  localparam int ST_STALL_BIT = 8;
  localparam int ST_DISCARD_BIT = 9;
  typedef enum logic [2:0] {ST_IDLE, ST_RDSLOT, ST_FETCH, ST_SETUP, ST_BUSY} seq_st_t;
  typedef enum logic [1:0] {OP_NONE, OP_LOAD, OP_ERASE, OP_PROG} op_t;
  typedef enum logic [1:0] {UL_IDLE, UL_FIRST, UL_ARMED} unl_t;
endpackage

/* rtl/nvm_core_bridge.sv */
`timescale 1ns/1ns
module nvm_core_bridge (
  input wire logic SYS_CLK,
  input wire logic RST_B,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  nvm_link_if.core LINK
);
  import nvm_pkg::*;

  logic reg_wr_ff;
  logic [IDX_W-1:0] reg_idx_ff, rd_idx_ff;
  logic [7:0] reg_wdata_ff;
  logic pready_ff, pslverr_ff, settle_ff;
  logic [31:0] prdata_ff, rd_word;
  logic busy, access, commit, mapped;

  //////////////////////////////////////////////////////////////////////////
  // Core stall: no request taken in idle slots or stalls
  // hold off in idle slots
  assign busy = LINK.stall || LINK.discard || reg_wr_ff || settle_ff;
  assign access = PSEL && PENABLE && !pready_ff && !busy;
  assign commit = PSEL && PENABLE && pready_ff && PWRITE;
  assign mapped = (PADDR == OFS_XFER) || (PADDR == OFS_RDSEL) || (PADDR == OFS_STATUS);

  always_comb begin
    rd_word = '0;
    if (PADDR == OFS_STATUS) begin
      rd_word[7:0] = LINK.rd_data;
      rd_word[ST_STALL_BIT] = LINK.stall;
      rd_word[ST_DISCARD_BIT] = LINK.discard;
    end else if (PADDR == OFS_RDSEL) begin
      rd_word[IDX_W-1:0] = rd_idx_ff;
    end else if (PADDR == OFS_XFER) begin
      rd_word[7:0] = reg_wdata_ff;
      rd_word[XFER_IDX_LSB +: IDX_W] = reg_idx_ff;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // APB answer
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= '0;
      settle_ff <= 1'b0;
    end else begin
      pready_ff <= access;
      pslverr_ff <= access && !mapped;
      settle_ff <= LINK.stall || LINK.discard || reg_wr_ff;
      if (access && !PWRITE) begin
        prdata_ff <= rd_word;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Register accesses toward the sequencer, one per transfer, in order
  // ordered register writes
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      reg_wr_ff <= 1'b0;
      reg_idx_ff <= '0;
      reg_wdata_ff <= '0;
      rd_idx_ff <= '0;
    end else begin
      reg_wr_ff <= commit && (PADDR == OFS_XFER);
      if (commit && (PADDR == OFS_XFER)) begin
        reg_idx_ff <= PWDATA[XFER_IDX_LSB +: IDX_W];
        reg_wdata_ff <= PWDATA[7:0];
      end else if (commit && (PADDR == OFS_RDSEL)) begin
        rd_idx_ff <= PWDATA[IDX_W-1:0];
      end
    end
  end

  assign PRDATA = prdata_ff;
  assign PREADY = pready_ff;
  assign PSLVERR = pslverr_ff;
  assign LINK.reg_wr = reg_wr_ff;
  assign LINK.reg_idx = reg_idx_ff;
  assign LINK.reg_wdata = reg_wdata_ff;
  assign LINK.rd_idx = rd_idx_ff;
endmodule // nvm_core_bridge

/* rtl/nvm_sequencer.sv */
// Our own choices: the register offsets and register access over APB.
`timescale 1ns/1ns
module nvm_sequencer #(
  parameter int LATCHES = nvm_pkg::LATCHES,
  parameter int ROW_WORDS = nvm_pkg::ROW_WORDS,
  parameter int FLASH_WORDS = nvm_pkg::FLASH_WORDS,
  parameter int ERASE_CYCLES = nvm_pkg::ERASE_CYCLES,
  parameter int WRITE_CYCLES = nvm_pkg::WRITE_CYCLES
) (
  input wire logic SYS_CLK,
  input wire logic RST_B,
  nvm_link_if.nvm LINK,
  output logic ARRAY_BUSY
);
  import nvm_pkg::*;

  localparam int LAW = $clog2(LATCHES);
  localparam int RAW = $clog2(ROW_WORDS);
  localparam int FAW = $clog2(FLASH_WORDS);
  localparam int BTAG_W = FAW - LAW;
  localparam int RTAG_W = FAW - RAW;
  localparam int HI_W = WORD_W - 8;

  logic [7:0] addr_lo_ff;
  logic [HI_W-1:0] addr_hi_ff;
  logic [7:0] data_lo_ff;
  logic [HI_W-1:0] data_hi_ff;
  logic rd_ff, wr_ff, wen_ff, free_ff, load_only_ff, cfg_sel_ff, pgd_ff;
  seq_st_t st_ff, nxt_st;
  op_t op_ff, nxt_op, kind;
  unl_t unl_ff;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic [WORD_W-1:0] flash_ff [FLASH_WORDS];
  logic [WORD_W-1:0] latch_ff [LATCHES];
  logic [7:0] rd_data_ff;
  logic stall_ff, discard_ff, busy_ff;
  logic [7:0] ctrl_rd;
  logic [WORD_W-1:0] waddr, data_word, fetched;
  logic to_flash, wr_ctrl, rd_go, wr_go, setup_end, done;
  logic latch_load, finish_prog, finish_erase;

  //////////////////////////////////////////////////////////////////////////
  // Decode
  assign waddr = {addr_hi_ff, addr_lo_ff};
  assign data_word = {data_hi_ff, data_lo_ff};
  assign to_flash = pgd_ff && !cfg_sel_ff;
  assign wr_ctrl = LINK.reg_wr && (LINK.reg_idx == RA_CTRL);
  assign rd_go = wr_ctrl && LINK.reg_wdata[B_RD] && (st_ff == ST_IDLE);
  assign wr_go = wr_ctrl && LINK.reg_wdata[B_WR] && (st_ff == ST_IDLE)
    && (unl_ff == UL_ARMED) && wen_ff;
  assign setup_end = (st_ff == ST_SETUP) && (cnt_ff == '0);
  assign done = (st_ff == ST_BUSY) && (cnt_ff == '0);
  assign latch_load = setup_end && ((op_ff == OP_LOAD) || (op_ff == OP_PROG));
  assign finish_prog = done && (op_ff == OP_PROG);
  assign finish_erase = done && (op_ff == OP_ERASE);
  assign fetched = to_flash ? flash_ff[waddr[FAW-1:0]] : '0;

  always_comb begin
    kind = OP_NONE;
    if (!to_flash) begin
      kind = OP_NONE;
    end else if (load_only_ff) begin
      kind = OP_LOAD;
    end else if (free_ff) begin
      kind = OP_ERASE;
    end else begin
      kind = OP_PROG;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    nxt_op = op_ff;
    case (st_ff)
      ST_IDLE: begin
        if (rd_go) begin
          nxt_st = ST_RDSLOT;
        end else if (wr_go) begin
          nxt_st = ST_SETUP;
          nxt_cnt = CNT_W'(SETUP_CYCLES - 1);
          nxt_op = kind;
        end
      end
      ST_RDSLOT: nxt_st = ST_FETCH;
      ST_FETCH: nxt_st = ST_IDLE;
      ST_SETUP: begin
        if (cnt_ff != '0) begin
          nxt_cnt = cnt_ff - 1'b1;
        end else if (op_ff == OP_ERASE) begin
          nxt_st = ST_BUSY;
          nxt_cnt = CNT_W'(ERASE_CYCLES - 1);
        end else if (op_ff == OP_PROG) begin
          nxt_st = ST_BUSY;
          nxt_cnt = CNT_W'(WRITE_CYCLES - 1);
        end else begin
          nxt_st = ST_IDLE;
        end
      end
      ST_BUSY: begin
        if (cnt_ff != '0) begin
          nxt_cnt = cnt_ff - 1'b1;
        end else begin
          nxt_st = ST_IDLE;
        end
      end
      default: nxt_st = ST_IDLE;
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      st_ff <= ST_IDLE;
      cnt_ff <= '0;
      op_ff <= OP_NONE;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      op_ff <= nxt_op;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      discard_ff <= 1'b0;
      stall_ff <= 1'b0;
      busy_ff <= 1'b0;
    end else begin
      discard_ff <= (nxt_st == ST_FETCH) || (nxt_st == ST_SETUP);
      stall_ff <= (nxt_st == ST_BUSY);
      busy_ff <= (nxt_st != ST_IDLE);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Unlock sequence, consumed by any other register write
  // 55h then AAh arms trigger
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      unl_ff <= UL_IDLE;
    end else if (LINK.reg_wr) begin
      if (LINK.reg_idx != RA_UNLOCK) begin
        unl_ff <= UL_IDLE;
      end else if (LINK.reg_wdata == KEY_FIRST) begin
        unl_ff <= UL_FIRST;
      end else if ((LINK.reg_wdata == KEY_SECOND) && (unl_ff == UL_FIRST)) begin
        unl_ff <= UL_ARMED;
      end else begin
        unl_ff <= UL_IDLE;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Control register
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      wen_ff <= 1'b0;
      load_only_ff <= 1'b0;
      cfg_sel_ff <= 1'b0;
      pgd_ff <= 1'b0;
    end else if (wr_ctrl) begin
      wen_ff <= LINK.reg_wdata[B_WEN];
      load_only_ff <= LINK.reg_wdata[B_LOAD_ONLY];
      cfg_sel_ff <= LINK.reg_wdata[B_CFG_SEL];
      pgd_ff <= LINK.reg_wdata[B_PGD];
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      rd_ff <= 1'b0;
      wr_ff <= 1'b0;
    end else begin
      if (rd_go) begin
        rd_ff <= 1'b1;
      end else if (st_ff == ST_FETCH) begin
        rd_ff <= 1'b0;
      end
      if (wr_go) begin
        wr_ff <= 1'b1;
      end else if (done || (setup_end && (nxt_st == ST_IDLE))) begin
        wr_ff <= 1'b0;
      end
    end
  end

  // erase select drops at erase end
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      free_ff <= 1'b0;
    end else if (wr_ctrl) begin
      free_ff <= LINK.reg_wdata[B_FREE];
    end else if (finish_erase) begin
      free_ff <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Address and data pairs
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      addr_lo_ff <= BYTE_ZERO;
      addr_hi_ff <= '0;
    end else if (LINK.reg_wr) begin
      if (LINK.reg_idx == RA_ADDR_LO) begin
        addr_lo_ff <= LINK.reg_wdata;
      end else if (LINK.reg_idx == RA_ADDR_HI) begin
        addr_hi_ff <= LINK.reg_wdata[HI_W-1:0];
      end
    end
  end

  // fetched word held until next change
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      data_lo_ff <= BYTE_ZERO;
      data_hi_ff <= '0;
    end else if (st_ff == ST_FETCH) begin
      data_lo_ff <= fetched[7:0];
      data_hi_ff <= fetched[WORD_W-1:8];
    end else if (LINK.reg_wr && (LINK.reg_idx == RA_DATA_LO)) begin
      data_lo_ff <= LINK.reg_wdata;
    end else if (LINK.reg_wr && (LINK.reg_idx == RA_DATA_HI)) begin
      data_hi_ff <= LINK.reg_wdata[HI_W-1:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Write latches and array
  generate
    for (genvar i = 0; i < LATCHES; i++) begin : g_latch
      always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
          latch_ff[i] <= ERASED_WORD;
        end else if (finish_prog) begin
          latch_ff[i] <= ERASED_WORD;
        end else if (latch_load && (waddr[LAW-1:0] == LAW'(i))) begin
          latch_ff[i] <= data_word;
        end
      end
    end
    for (genvar i = 0; i < FLASH_WORDS; i++) begin : g_word
      always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
          flash_ff[i] <= ERASED_WORD;
        end else if (finish_erase && (waddr[FAW-1:RAW] == RTAG_W'(i / ROW_WORDS))) begin
          flash_ff[i] <= ERASED_WORD;
        end else if (finish_prog && (waddr[FAW-1:LAW] == BTAG_W'(i / LATCHES))) begin
          flash_ff[i] <= flash_ff[i] & latch_ff[i % LATCHES];
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // Read-back
  always_comb begin
    ctrl_rd = BYTE_ZERO;
    ctrl_rd[B_RD] = rd_ff;
    ctrl_rd[B_WR] = wr_ff;
    ctrl_rd[B_WEN] = wen_ff;
    ctrl_rd[B_WRERR] = 1'b0;
    ctrl_rd[B_FREE] = free_ff;
    ctrl_rd[B_LOAD_ONLY] = load_only_ff;
    ctrl_rd[B_CFG_SEL] = cfg_sel_ff;
    ctrl_rd[B_PGD] = pgd_ff;
  end

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      rd_data_ff <= BYTE_ZERO;
    end else if (LINK.rd_idx == RA_ADDR_LO) begin
      rd_data_ff <= addr_lo_ff;
    end else if (LINK.rd_idx == RA_ADDR_HI) begin
      rd_data_ff <= 8'(addr_hi_ff);
    end else if (LINK.rd_idx == RA_DATA_LO) begin
      rd_data_ff <= data_lo_ff;
    end else if (LINK.rd_idx == RA_DATA_HI) begin
      rd_data_ff <= 8'(data_hi_ff);
    end else if (LINK.rd_idx == RA_CTRL) begin
      rd_data_ff <= ctrl_rd;
    end else begin
      rd_data_ff <= BYTE_ZERO;
    end
  end

  assign LINK.rd_data = rd_data_ff;
  assign LINK.stall = stall_ff;
  assign LINK.discard = discard_ff;
  assign ARRAY_BUSY = busy_ff;
endmodule // nvm_sequencer

/* tb/flash_program_memory_sequencer_test.sv */
`timescale 1ns/1ns
module flash_program_memory_sequencer_test;
  import nvm_pkg::*;
  localparam int STALL = 20;
  localparam logic [7:0] M_RD = 8'h01 << B_RD;
  localparam logic [7:0] M_WR = 8'h01 << B_WR;
  localparam logic [7:0] M_WEN = 8'h01 << B_WEN;
  localparam logic [7:0] M_FREE = 8'h01 << B_FREE;
  localparam logic [7:0] M_LOAD_ONLY = 8'h01 << B_LOAD_ONLY;
  localparam logic [7:0] M_CFG_SEL = 8'h01 << B_CFG_SEL;
  localparam logic [7:0] M_PGD = 8'h01 << B_PGD;
  localparam logic [7:0] M_EN = M_PGD | M_WEN;
  logic SYS_CLK = 1'b0;
  logic RST_B = 1'b0;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0;
  logic [31:0] PRDATA;
  logic PREADY;
  logic PSLVERR;
  logic array_busy;
  int fails = 0;
  int checks_done = 0;
  logic [32:0] exp_q[$];
  logic [31:0] lfsr = 32'h42eeca6e;
  logic [31:0] r;
  logic [13:0] v[5];
  logic [7:0] base;
  logic [7:0] base2;
  nvm_link_if link();
  nvm_sequencer #(.ERASE_CYCLES(STALL), .WRITE_CYCLES(STALL)) u_nvm_sequencer (
    .SYS_CLK(SYS_CLK), .RST_B(RST_B), .LINK(link), .ARRAY_BUSY(array_busy));
  nvm_core_bridge u_nvm_core_bridge (
    .SYS_CLK(SYS_CLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .LINK(link));
  nvm_link_props #(.STALL_CYCLES(STALL)) u_nvm_link_props (
    .SYS_CLK(SYS_CLK), .RST_B(RST_B), .reg_wr(link.reg_wr), .reg_idx(link.reg_idx),
    .reg_wdata(link.reg_wdata), .rd_idx(link.rd_idx), .rd_data(link.rd_data),
    .stall(link.stall), .discard(link.discard), .busy(array_busy));
  initial begin
    forever #25 SYS_CLK = ~SYS_CLK;
  end
  //////////////////////////////
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  task automatic check(input logic [32:0] seen, input logic [32:0] want);
    checks_done++;
    if (seen !== want) begin
      fails++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask
  task automatic test_done();
    if (fails == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // One APB transfer, held until the slave answers
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge SYS_CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge SYS_CLK);
    PENABLE <= 1'b1;
    @(posedge SYS_CLK);
    while (PREADY !== 1'b1) @(posedge SYS_CLK);
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic set(input logic [2:0] i, input logic [7:0] b);
    apb(1'b1, OFS_XFER, {21'h0, i, b});
  endtask
  task automatic get(input logic [2:0] i, input logic [7:0] b);
    apb(1'b1, OFS_RDSEL, {29'h0, i});
    exp_q.push_back({25'h0, b});
    apb(1'b0, OFS_STATUS, 32'h0);
  endtask
  task automatic trig(input logic [7:0] c);
    set(RA_UNLOCK, KEY_FIRST);
    set(RA_UNLOCK, KEY_SECOND);
    set(RA_CTRL, c | M_WR);
  endtask
  task automatic word(input logic [7:0] a, input logic [7:0] c, input logic [13:0] e);
    set(RA_ADDR_LO, a);
    set(RA_ADDR_HI, 8'h00);
    set(RA_CTRL, c | M_RD);
    get(RA_DATA_LO, e[7:0]);
    get(RA_DATA_HI, {2'b00, e[13:8]});
  endtask
  task automatic load(input logic [7:0] a, input logic [13:0] d, input logic [7:0] c);
    set(RA_ADDR_LO, a);
    set(RA_ADDR_HI, 8'h00);
    set(RA_DATA_LO, d[7:0]);
    set(RA_DATA_HI, {2'b00, d[13:8]});
    set(RA_CTRL, c);
    trig(c);
  endtask
  //////////////////////////////
  // Read results checked in order of request
  initial begin
    forever begin
      @(posedge SYS_CLK);
      if (PSEL && PENABLE && PREADY === 1'b1 && !PWRITE)
        check({PSLVERR, PRDATA}, exp_q.size() > 0 ? exp_q.pop_front() : 33'bx);
    end
  end
  initial begin
    repeat (100000) @(posedge SYS_CLK);
    fails++;
    test_done();
  end
  initial begin
    repeat (6) @(posedge SYS_CLK);
    RST_B <= 1'b1;
    for (int i = 0; i < 6; i++) get(3'(i), 8'h00);
    exp_q.push_back({1'b1, 32'h0});
    apb(1'b0, 12'h00c, 32'h0);
    word(8'h05, M_PGD, ERASED_WORD);
    get(RA_CTRL, M_PGD);
    set(RA_DATA_LO, 8'h5a);
    get(RA_DATA_LO, 8'h5a);
    set(RA_CTRL, M_EN);
    set(RA_CTRL, M_EN | M_WR);
    get(RA_CTRL, M_EN);
    set(RA_CTRL, M_PGD);
    trig(M_EN);
    get(RA_CTRL, M_EN);
    r = rnd();
    base = {r[7:5], 5'h00};
    base2 = base ^ 8'h20;
    for (int k = 0; k < 5; k++) begin
      r = rnd();
      v[k] = r[13:0];
    end
    for (int k = 0; k < 4; k++) load(base + 8'(k), v[k], M_EN | M_LOAD_ONLY);
    get(RA_CTRL, M_EN | M_LOAD_ONLY);
    word(base, M_PGD, ERASED_WORD);
    load(base + 8'd31, v[4], M_EN);
    for (int k = 0; k < 32; k++)
      word(base + 8'(k), M_PGD, k < 4 ? v[k] : (k == 31 ? v[4] : ERASED_WORD));
    word(base2, M_PGD, ERASED_WORD);
    load(base2 + 8'd31, v[0], M_EN);
    word(base2, M_PGD, ERASED_WORD);
    load(base + 8'd31, v[1], M_EN);
    word(base + 8'd31, M_PGD, v[4] & v[1]);
    set(RA_ADDR_LO, base + 8'd7);
    set(RA_CTRL, M_EN | M_FREE);
    trig(M_EN | M_FREE);
    get(RA_CTRL, M_EN);
    word(base, M_PGD, ERASED_WORD);
    word(base + 8'd31, M_PGD, ERASED_WORD);
    word(base2 + 8'd31, M_PGD, v[0]);
    word(base2 + 8'd31, 8'h00, 14'h0);
    word(base2 + 8'd31, M_PGD | M_CFG_SEL, 14'h0);
    test_done();
  end
endmodule // flash_program_memory_sequencer_test

/* tb/nvm_link_props.sv */
`timescale 1ns/1ns
module nvm_link_props #(
  parameter int STALL_CYCLES = 20
) (
  input wire logic SYS_CLK,
  input wire logic RST_B,
  input wire logic reg_wr,
  input wire logic [2:0] reg_idx,
  input wire logic [7:0] reg_wdata,
  input wire logic [2:0] rd_idx,
  input wire logic [7:0] rd_data,
  input wire logic stall,
  input wire logic discard,
  input wire logic busy
);
  import nvm_pkg::*;
  logic [1:0] key_ff;
  logic wen_ff;
  logic [15:0] stall_cnt_ff;
  logic [1:0] quiet_ff;
  logic [2:0] idx_ff;
  wire logic ctrl_w = reg_wr && reg_idx == RA_CTRL;
  wire logic trig_w = ctrl_w && reg_wdata[B_WR] && !reg_wdata[B_RD];
  wire logic rd_trig_w = ctrl_w && reg_wdata[B_RD] && !reg_wdata[B_WR];
  //////////////////////////////
  // Unlock and enable tracking
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) key_ff <= 2'd0;
    else if (reg_wr && reg_idx == RA_UNLOCK && reg_wdata == KEY_FIRST) key_ff <= 2'd1;
    else if (reg_wr && reg_idx == RA_UNLOCK && reg_wdata == KEY_SECOND && key_ff == 2'd1)
      key_ff <= 2'd2;
    else if (reg_wr) key_ff <= 2'd0;
  end
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) wen_ff <= 1'b0;
    else if (ctrl_w) wen_ff <= reg_wdata[B_WEN];
  end
  // Length of the current halt
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) stall_cnt_ff <= 16'h0;
    else stall_cnt_ff <= stall ? stall_cnt_ff + 16'h1 : 16'h0;
  end
  // Cycles with nothing able to change the read port
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) quiet_ff <= 2'd0;
    else if (reg_wr || discard || stall || rd_idx != idx_ff) quiet_ff <= 2'd0;
    else if (quiet_ff != 2'd3) quiet_ff <= quiet_ff + 2'd1;
  end
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) idx_ff <= 3'h0;
    else idx_ff <= rd_idx;
  end
  //////////////////////////////
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);
  sequence seq_setup;
    discard ##1 discard ##1 !discard;
  endsequence
  sequence seq_fetch;
    !discard ##1 discard ##1 !discard;
  endsequence
  sequence seq_locked;
    !discard [*4];
  endsequence
  AST_QUIET_WHEN_BUSY: assert property ((stall || discard) |-> !reg_wr)
    else $error("link write while core halted");
  AST_WRITE_SETUP: assert property (
    trig_w && key_ff == 2'd2 && wen_ff |-> ##[1:3] seq_setup)
    else $error("write trigger setup slots wrong");
  AST_READ_SLOT: assert property (rd_trig_w |-> ##[1:3] seq_fetch)
    else $error("read fetch slot wrong");
  AST_STALL_AFTER_SETUP: assert property (
    $rose(stall) |-> $past(discard) || $past(discard, 2))
    else $error("halt without setup slots");
  AST_BUSY_COVERS: assert property ((stall || discard) |-> busy)
    else $error("busy flag low while core halted");
  AST_BUSY_ON_READ: assert property (rd_trig_w |-> ##1 busy)
    else $error("busy flag low after read trigger");
  AST_STALL_LENGTH: assert property ($fell(stall) |-> stall_cnt_ff == 16'(STALL_CYCLES))
    else $error("halt length wrong");
  AST_NO_WRITE_UNLOCKED: assert property (trig_w && key_ff != 2'd2 |-> ##1 seq_locked)
    else $error("write trigger taken without unlock");
  AST_NO_WRITE_DISABLED: assert property (trig_w && !wen_ff |-> ##1 seq_locked)
    else $error("write trigger taken without enable");
  AST_READ_HOLD: assert property (quiet_ff == 2'd3 |-> $stable(rd_data))
    else $error("register value changed by itself");
endmodule // nvm_link_props
